//--- hdl/fos_dev_end.sv
// device end: sequencer with status byte
//
// Overview of operation
// (RULE1) program failure flag stays until clear or reset
// (RULE2) low program-enable pin sets supply error flag
// (RULE3) buffered program does not report supply error
// (RULE4) supply error flag stays until clear or reset
// (RULE5) clear error flags before new operations
// (RULE6) program suspend flag high only while paused
// (RULE7) suspend flags valid only when idle bit high
// (RULE8) resume returns program suspend flag low
// (RULE9) protected target sets protect and fail flag
// (RULE10) protect flag stays until clear or reset
// (RULE11) host masks reserved bit zero
// (RULE12) busy: idle bit and bits six-one low
// (RULE13) ready status 80h, C0h in erase suspend
// (RULE14) paused program 84h, C4h inside erase suspend
// (RULE15) bad sequence sets both failures, B0h or F0h
// (RULE16) supply error codes 98h, D8h, A8h
// (RULE17) protect violation codes 92h, D2h, A2h
// (RULE18) cell failure codes 90h, D0h, A0h
// (RULE19) successful erase or unprotect gives 80h
// (RULE20) status byte on lowest eight data lines
// (RULE21) idle bit low while sequencer runs
// (RULE22) erase suspend flag high while erase paused
// (RULE23) erase failure flag on erase verify failure
// (RULE24) clear resets all four error flags together
//
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module fos_dev_end
    import fos_pkg::*;
#(
    parameter int PROG_CYCLES   = PROG_CYC,
    parameter int ERASE_CYCLES  = ERASE_CYC_DEF,
    parameter int UNPROT_CYCLES = UNPROT_CYC_DEF,
    parameter int SUSP_CYCLES   = SUSP_CYC
) (
    input  wire logic mclk,
    input  wire logic resetn,
    fos_if.dev        lnk,
    input  wire logic tgtProtected,
    input  wire logic cellFail,
    output logic      seqBusy
);
    // ==========================================================
    // parameter checks
    // ==========================================================
    initial begin
        if (PROG_CYCLES < 1 || ERASE_CYCLES < 1 || UNPROT_CYCLES < 1 ||
            ERASE_CYCLES >= (1 << CNT_W) || UNPROT_CYCLES >= (1 << CNT_W) ||
            PROG_CYCLES >= (1 << CNT_W)) begin
            $error("fos_dev_end: operation count out of range");
        end
        if (SUSP_CYCLES < 1 || SUSP_CYCLES >= (1 << SLAT_W)) begin
            $error("fos_dev_end: suspend latency out of range");
        end
    end

    typedef struct packed {
        fos_seq_t          st;
        logic [CNT_W-1:0]  cnt;        // cycles left in running op
        logic [CNT_W-1:0]  eraseCnt;   // cycles left of paused erase
        logic [SLAT_W-1:0] slat;       // suspend latency left
        logic              isErase;    // running op is erase/unprotect
        logic              progSusp;
        logic              eraseSusp;
        logic [1:0]        vppSync;
        logic [7:0]        dqOut;
        logic [7:0]        dqOe;
        logic              busy;
    } fos_dev_st_t;

    fos_dev_st_t s_q;
    fos_dev_st_t s_d;

    logic ersFail;
    logic prgFail;
    logic vppErr;
    logic protErr;
    logic setErs;
    logic setPrg;
    logic setVpp;
    logic setProt;
    logic clrFlags;
    logic vppOk;
    logic anyErr;
    logic isProgCmd;
    logic isEraseCmd;
    logic [7:0] stsByte;

    // ==========================================================
    // sticky error flags
    // ==========================================================
    fos_sticky_flag u_ersFail (
        .mclk     (mclk),
        .resetn   (resetn),
        .setPulse (setErs),
        .clrPulse (clrFlags),
        .flag     (ersFail)
    );
    fos_sticky_flag u_prgFail (
        .mclk     (mclk),
        .resetn   (resetn),
        .setPulse (setPrg),
        .clrPulse (clrFlags),
        .flag     (prgFail)
    );
    fos_sticky_flag u_vppErr (
        .mclk     (mclk),
        .resetn   (resetn),
        .setPulse (setVpp),
        .clrPulse (clrFlags),
        .flag     (vppErr)
    );
    fos_sticky_flag u_protErr (
        .mclk     (mclk),
        .resetn   (resetn),
        .setPulse (setProt),
        .clrPulse (clrFlags),
        .flag     (protErr)
    );

    // ==========================================================
    // command decode helpers
    // ==========================================================
    assign vppOk      = s_q.vppSync[1];
    assign anyErr     = ersFail | prgFail | vppErr | protErr;
    assign isProgCmd  = (lnk.cmdCode == CMD_WORD_PROG) ||
                        (lnk.cmdCode == CMD_BUF_PROG) ||
                        (lnk.cmdCode == CMD_PROTECT);
    assign isEraseCmd = (lnk.cmdCode == CMD_ERASE) ||
                        (lnk.cmdCode == CMD_UNPROT);

    // status byte while the sequencer is inactive
    always_comb begin
        stsByte               = 8'h00;
        stsByte[BIT_IDLE]     = 1'b1;                 // RULE21
        stsByte[BIT_ERS_SUSP] = s_q.eraseSusp;        // RULE22
        stsByte[BIT_ERS_FAIL] = ersFail;              // RULE23
        stsByte[BIT_PRG_FAIL] = prgFail;              // RULE1
        stsByte[BIT_VPP_ERR]  = vppErr;               // RULE4
        stsByte[BIT_PRG_SUSP] = s_q.progSusp;         // RULE6
        stsByte[BIT_PROT_ERR] = protErr;              // RULE10
    end

    // ==========================================================
    // sequencer next state
    // ==========================================================
    always_comb begin
        s_d      = s_q;
        setErs   = 1'b0;
        setPrg   = 1'b0;
        setVpp   = 1'b0;
        setProt  = 1'b0;
        clrFlags = 1'b0;
        s_d.vppSync = {s_q.vppSync[0], lnk.vppLvl};
        case (s_q.st)
            SEQ_IDLE: begin
                if (lnk.cmdValid) begin
                    if (lnk.cmdCode == CMD_CLEAR) begin
                        clrFlags = 1'b1;                          // RULE24
                    end else if (lnk.cmdCode == CMD_RESUME) begin
                        if (s_q.progSusp) begin
                            s_d.progSusp = 1'b0;                  // RULE8
                            s_d.st       = SEQ_RUN;
                        end else if (s_q.eraseSusp) begin
                            s_d.eraseSusp = 1'b0;                 // RULE22
                            s_d.cnt       = s_q.eraseCnt;
                            s_d.isErase   = 1'b1;
                            s_d.st        = SEQ_RUN;
                        end
                    end else if (lnk.cmdCode == CMD_BAD_SEQ) begin
                        setErs = 1'b1;                            // RULE15
                        setPrg = 1'b1;                            // RULE15
                    end else if (s_q.progSusp || anyErr) begin
                        // refused while flags stand
                        s_d.st = SEQ_IDLE;                        // RULE5
                    end else if (isProgCmd) begin
                        if (s_q.eraseSusp &&
                            lnk.cmdCode == CMD_PROTECT) begin
                            s_d.st = SEQ_IDLE;
                        end else if (!vppOk &&
                                     lnk.cmdCode != CMD_BUF_PROG) begin
                            setVpp = 1'b1;                        // RULE2
                            setPrg = 1'b1;                        // RULE16
                        end else if (tgtProtected &&
                                     lnk.cmdCode != CMD_PROTECT) begin
                            setProt = 1'b1;                       // RULE9
                            setPrg  = 1'b1;                       // RULE17
                        end else begin
                            // buffered program runs even with pin low
                            s_d.isErase = 1'b0;                   // RULE3
                            s_d.cnt     = CNT_W'(PROG_CYCLES);
                            s_d.st      = SEQ_RUN;
                        end
                    end else if (isEraseCmd && !s_q.eraseSusp) begin
                        if (!vppOk) begin
                            setVpp = 1'b1;                        // RULE2
                            setErs = 1'b1;                        // RULE16
                        end else if (tgtProtected &&
                                     lnk.cmdCode == CMD_ERASE) begin
                            setProt = 1'b1;                       // RULE9
                            setErs  = 1'b1;                       // RULE17
                        end else begin
                            s_d.isErase = 1'b1;
                            s_d.cnt     = (lnk.cmdCode == CMD_ERASE) ?
                                          CNT_W'(ERASE_CYCLES) :
                                          CNT_W'(UNPROT_CYCLES);
                            s_d.st      = SEQ_RUN;
                        end
                    end
                end
            end
            SEQ_RUN, SEQ_SUSPEND: begin
                s_d.cnt = s_q.cnt - CNT_W'(1);
                if (s_q.st == SEQ_SUSPEND) begin
                    s_d.slat = s_q.slat - SLAT_W'(1);
                end else if (lnk.cmdValid && lnk.cmdCode == CMD_SUSPEND) begin
                    s_d.slat = SLAT_W'(SUSP_CYCLES);
                    s_d.st   = SEQ_SUSPEND;
                end
                if (s_q.cnt == CNT_W'(1)) begin
                    // op done, maybe before pausing
                    s_d.st = SEQ_IDLE;                            // RULE7
                    if (cellFail) begin
                        setErs = s_q.isErase;                     // RULE18
                        setPrg = !s_q.isErase;                    // RULE18
                    end
                end else if (s_q.st == SEQ_SUSPEND &&
                             s_q.slat == SLAT_W'(1)) begin
                    s_d.st = SEQ_IDLE;
                    if (s_q.isErase) begin
                        s_d.eraseSusp = 1'b1;                     // RULE22
                        s_d.eraseCnt  = s_d.cnt;
                    end else begin
                        s_d.progSusp  = 1'b1;                     // RULE6
                    end
                end
            end
            default: begin
                s_d.st = SEQ_IDLE;
            end
        endcase

        // status drive from current state
        s_d.busy = (s_d.st != SEQ_IDLE);
        if (s_q.st != SEQ_IDLE) begin
            s_d.dqOut = 8'h00;                                    // RULE12
        end else begin
            s_d.dqOut = stsByte;                                  // RULE13
        end
        s_d.dqOe = lnk.statRd ? RSVD_MASK : 8'h00;                // RULE20
    end

    // ==========================================================
    // state register
    // ==========================================================
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign lnk.dqOut = s_q.dqOut;
    assign lnk.dqOe  = s_q.dqOe;
    assign seqBusy   = s_q.busy;
endmodule // fos_dev_end

//--- hdl/fos_pkg.sv
// package: shared constants and types
package fos_pkg;

    // ==========================================================
    // clock and timing
    // ==========================================================
    localparam int CLK_PERIOD_NS   = 50;
    localparam int WORD_PROG_NS    = 18000;   // typical word program time
    localparam int SUSP_LAT_NS     = 20000;   // longest suspend latency
    // cycle counts, floor of one
    localparam int PROG_CYC_I      = WORD_PROG_NS / CLK_PERIOD_NS;
    localparam int SUSP_CYC_I      = SUSP_LAT_NS / CLK_PERIOD_NS;
    localparam int PROG_CYC        = (PROG_CYC_I < 1) ? 1 : PROG_CYC_I;
    localparam int SUSP_CYC        = (SUSP_CYC_I < 1) ? 1 : SUSP_CYC_I;
    localparam int ERASE_S_MS      = 1100;    // typical block erase, ms
    localparam int UNPROT_S_MS     = 750;     // typical unprotect all, ms
    localparam int ERASE_CYC_DEF   = ERASE_S_MS * (1000000 / CLK_PERIOD_NS);
    localparam int UNPROT_CYC_DEF  = UNPROT_S_MS * (1000000 / CLK_PERIOD_NS);
    localparam int CNT_W           = 25;
    localparam int SLAT_W          = 9;

    // ==========================================================
    // command codes on the link
    // ==========================================================
    localparam logic [3:0] CMD_NONE      = 4'h0;
    localparam logic [3:0] CMD_WORD_PROG = 4'h1;
    localparam logic [3:0] CMD_BUF_PROG  = 4'h2;   // buffered_write_op
    localparam logic [3:0] CMD_ERASE     = 4'h3;
    localparam logic [3:0] CMD_PROTECT   = 4'h4;
    localparam logic [3:0] CMD_UNPROT    = 4'h5;
    localparam logic [3:0] CMD_SUSPEND   = 4'h6;
    localparam logic [3:0] CMD_RESUME    = 4'h7;
    localparam logic [3:0] CMD_CLEAR     = 4'h8;
    localparam logic [3:0] CMD_BAD_SEQ   = 4'h9;   // malformed sequence

    // ==========================================================
    // status byte layout
    // ==========================================================
    localparam int BIT_IDLE      = 7;
    localparam int BIT_ERS_SUSP  = 6;
    localparam int BIT_ERS_FAIL  = 5;
    localparam int BIT_PRG_FAIL  = 4;
    localparam int BIT_VPP_ERR   = 3;
    localparam int BIT_PRG_SUSP  = 2;
    localparam int BIT_PROT_ERR  = 1;
    localparam int BIT_RSVD      = 0;
    localparam logic [7:0] ERR_MASK  = 8'h3A;
    localparam logic [7:0] RSVD_MASK = 8'hFE;

    // ==========================================================
    // host register map (AHB-Lite byte offsets)
    // ==========================================================
    localparam logic [7:0] OFS_CMD    = 8'h00;
    localparam logic [7:0] OFS_CTRL   = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam int CTRL_VPP     = 0;
    localparam int CTRL_STATRD  = 1;
    localparam int STS_VALID    = 8;
    localparam int STS_REFUSED  = 9;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // ==========================================================
    // device sequencer states
    // ==========================================================
    typedef enum logic [1:0] {
        SEQ_IDLE    = 2'b00,
        SEQ_RUN     = 2'b01,
        SEQ_SUSPEND = 2'b10
    } fos_seq_t;

endpackage

//--- hdl/fos_if.sv
// interface: command and status link
`timescale 1ns/1ps
interface fos_if;
    logic       cmdValid;   // one-cycle command strobe
    logic [3:0] cmdCode;
    logic       vppLvl;     // program-enable pin level
    logic       statRd;     // host output enable for status reads
    logic [7:0] dqOut;      // device drive value
    logic [7:0] dqOe;       // device drive enables
    logic [7:0] dqLvl;      // undriven bits read low

    // ==========================================================
    // wire resolution of the data lines
    // ==========================================================
    assign dqLvl = dqOut & dqOe;

    modport dev  (input cmdValid, cmdCode, vppLvl, statRd,
                  output dqOut, dqOe);
    modport host (output cmdValid, cmdCode, vppLvl, statRd,
                  input dqLvl, dqOe);
endinterface

//--- hdl/fos_sticky_flag.sv
// sticky status flag: set wins, clear or reset
`timescale 1ns/1ps
module fos_sticky_flag (
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic setPulse,
    input  wire logic clrPulse,
    output logic      flag
);
    typedef struct packed {
        logic flag;
    } fos_flag_st_t;

    fos_flag_st_t s_q;
    fos_flag_st_t s_d;

    // set wins over a clear in the same cycle
    always_comb begin
        s_d = s_q;
        if (setPulse) begin
            s_d.flag = 1'b1;
        end else if (clrPulse) begin
            s_d.flag = 1'b0;
        end
    end

    // ==========================================================
    // state register
    // ==========================================================
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign flag = s_q.flag;
endmodule // fos_sticky_flag

//--- hdl/fos_host_end.sv
// host end: AHB-Lite front of the status link
`timescale 1ns/1ps
module fos_host_end
    import fos_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    fos_if.host              lnk
);
    typedef struct packed {
        logic        wrPend;
        logic [7:0]  wrAddr;
        logic [31:0] rdData;
        logic [1:0]  ctrl;
        logic [7:0]  stsByte;
        logic        refused;
        logic        cmdValid;
        logic [3:0]  cmdCode;
        logic        hreadyout;
    } fos_host_st_t;

    fos_host_st_t s_q;
    fos_host_st_t s_d;

    logic        addrPh;
    logic [3:0]  newCmd;
    logic        opCmd;
    logic [31:0] statusWord;

    assign addrPh = hsel & htrans[1] & hready;
    assign newCmd = hwdata[3:0];
    assign opCmd  = (newCmd == CMD_WORD_PROG) || (newCmd == CMD_BUF_PROG) ||
                    (newCmd == CMD_ERASE) || (newCmd == CMD_PROTECT) ||
                    (newCmd == CMD_UNPROT);

    // status word, bit0 masked, idle marks valid
    always_comb begin
        statusWord              = 32'h0000_0000;
        statusWord[7:0]         = s_q.stsByte & RSVD_MASK;         // RULE11
        statusWord[STS_VALID]   = s_q.stsByte[BIT_IDLE];           // RULE7
        statusWord[STS_REFUSED] = s_q.refused;
    end

    // ==========================================================
    // bus slave and link control
    // ==========================================================
    always_comb begin
        s_d           = s_q;
        s_d.cmdValid  = 1'b0;
        s_d.hreadyout = 1'b1;
        if (s_q.ctrl[CTRL_STATRD]) begin
            s_d.stsByte = lnk.dqLvl;
        end
        if (s_q.wrPend) begin
            s_d.wrPend = 1'b0;
            if (s_q.wrAddr == OFS_CMD) begin
                if (opCmd && (s_q.stsByte & ERR_MASK) != 8'h00) begin
                    s_d.refused = 1'b1;                            // RULE5
                end else begin
                    s_d.cmdValid = 1'b1;
                    s_d.cmdCode  = newCmd;
                    if (newCmd == CMD_CLEAR) begin
                        s_d.refused = 1'b0;
                        s_d.stsByte = s_q.stsByte & ~ERR_MASK;
                    end
                end
            end else if (s_q.wrAddr == OFS_CTRL) begin
                s_d.ctrl = hwdata[1:0];
            end
        end
        if (addrPh) begin
            s_d.wrPend = hwrite;
            s_d.wrAddr = haddr[7:0];
            if (haddr[7:0] == OFS_CTRL) begin
                s_d.rdData = {30'h0, s_q.ctrl};
            end else if (haddr[7:0] == OFS_STATUS) begin
                s_d.rdData = statusWord;
            end else begin
                s_d.rdData = 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // state register
    // ==========================================================
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_q      <= '0;
            s_q.ctrl <= CTRL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata       = s_q.rdData;
    assign hreadyout    = s_q.hreadyout;
    assign hresp        = 1'b0;
    assign lnk.cmdValid = s_q.cmdValid;
    assign lnk.cmdCode  = s_q.cmdCode;
    assign lnk.vppLvl   = s_q.ctrl[CTRL_VPP];
    assign lnk.statRd   = s_q.ctrl[CTRL_STATRD];
endmodule // fos_host_end

//--- tb/fos_link_properties.sv
// checker: status link properties
`timescale 1ns/1ps
module fos_link_properties
    import fos_pkg::*;
(
    input wire logic       mclk,
    input wire logic       resetn,
    input wire logic       cmdValid,
    input wire logic [3:0] cmdCode,
    input wire logic       vppLvl,
    input wire logic       statRd,
    input wire logic [7:0] dqOut,
    input wire logic [7:0] dqOe,
    input wire logic [7:0] dqLvl
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    // ==========================================================
    // command sequences
    // ==========================================================
    logic clrNow;
    assign clrNow = cmdValid && (cmdCode == CMD_CLEAR);
    sequence s_clrCmd;
        clrNow && dqOut[7] && !$past(cmdValid);
    endsequence
    sequence s_vppLowProg;
        (!vppLvl)[*4] ##0 (cmdValid && cmdCode == CMD_WORD_PROG
            && dqOut[7:1] == 7'h40);
    endsequence

    // ==========================================================
    // properties
    // ==========================================================
    property p_rsvdBit;
        dqOe[0] == 1'b0 && dqLvl[0] == 1'b0;
    endproperty
    a_rsvdBit: assert property (p_rsvdBit)
        else $error("reserved bit driven");
    property p_busyByte;
        !dqOut[7] |-> dqOut[7:1] == 7'h00;
    endproperty
    a_busyByte: assert property (p_busyByte)
        else $error("busy byte not zero");
    property p_oeFollow;
        dqOe[7:1] == {7{$past(statRd)}};
    endproperty
    a_oeFollow: assert property (p_oeFollow)
        else $error("enable lag");
    property p_sticky;
        dqOut[7] && !clrNow && !$past(clrNow) |=>
            (dqOut & $past(dqOut) & ERR_MASK) == ($past(dqOut) & ERR_MASK);
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag dropped");
    property p_clear;
        s_clrCmd |-> ##2 ((dqOut & ERR_MASK) == 8'h00) && dqOut[7]
            && (dqOut[6] == $past(dqOut[6], 2));
    endproperty
    a_clear: assert property (p_clear)
        else $error("flags not cleared");
    property p_protFlag;
        dqOut[7] && dqOut[1] |-> dqOut[4] || dqOut[5];
    endproperty
    a_protFlag: assert property (p_protFlag)
        else $error("protect flag alone");
    property p_vppErr;
        s_vppLowProg |-> ##[1:40] dqOut[7:1] == 7'h4C;
    endproperty
    a_vppErr: assert property (p_vppErr)
        else $error("supply error code missing");
    property p_resume;
        dqOut[7] && dqOut[2] && cmdValid && cmdCode == CMD_RESUME
            |-> ##[1:3] !dqOut[2];
    endproperty
    a_resume: assert property (p_resume)
        else $error("suspend stuck");
endmodule // fos_link_properties

//--- tb/tb.sv
// testbench: both ends over the link
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    errCount++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb
    import fos_pkg::*;
;
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hsel = 1'b0;
    logic        hresp;
    logic        tgtProt = 1'b0;
    logic        cellBad = 1'b0;
    logic        seqBusy;
    logic [31:0] rd;
    logic [22:0] rows [14];
    int          errCount = 0;
    int          comparisons = 0;

    // ==========================================================
    // the two ends and the checker
    // ==========================================================
    fos_if lnk ();
    fos_dev_end #(.PROG_CYCLES(16), .ERASE_CYCLES(40),
        .UNPROT_CYCLES(24), .SUSP_CYCLES(4)) u_fos_dev_end (
        .mclk(mclk), .resetn(resetn), .lnk(lnk), .tgtProtected(tgtProt),
        .cellFail(cellBad), .seqBusy(seqBusy));
    fos_host_end u_fos_host_end (.mclk(mclk), .resetn(resetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lnk(lnk));
    fos_link_properties u_fos_link_properties (.mclk(mclk),
        .resetn(resetn), .cmdValid(lnk.cmdValid), .cmdCode(lnk.cmdCode),
        .vppLvl(lnk.vppLvl), .statRd(lnk.statRd), .dqOut(lnk.dqOut),
        .dqOe(lnk.dqOe), .dqLvl(lnk.dqLvl));

    // clock
    always #25 mclk = ~mclk;

    // one AHB transfer
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        hsel   <= 1'b1;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        rd = hrdata;
    endtask

    // pin levels, settle, command
    task automatic op(input logic [3:0] c, input logic v,
                      input logic pr, input logic cf);
        tgtProt <= pr;
        cellBad <= cf;
        ahb(1'b1, OFS_CTRL, {30'h0, 1'b1, v});
        repeat (4) @(posedge mclk);
        ahb(1'b1, OFS_CMD, {28'h0, c});
    endtask

    // wait until idle byte reaches host
    task automatic settle();
        repeat (3) @(posedge mclk);
        while (seqBusy !== 1'b0) @(posedge mclk);
        repeat (4) @(posedge mclk);
    endtask

    // status word, bit0 masked
    task automatic chkSt(input logic [7:0] e, input logic r);
        ahb(1'b0, OFS_STATUS, 32'h0);
        `CHK("hresp", 1'b0, hresp)
        `CHK("status", {r, 1'b1, e[7:1]}, rd[9:1])
    endtask

    task automatic giveVerdict();
        $display("comparisons %0d mismatches %0d", comparisons, errCount);
        if (errCount == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        #1000000;
        errCount++;
        giveVerdict();
    end

    // table pass plain, then in erase suspend
    initial begin
        rows = '{{CMD_WORD_PROG, 3'b100, 8'h80, 8'hC0},
                 {CMD_BUF_PROG,  3'b000, 8'h80, 8'hC0},
                 {CMD_PROTECT,   3'b100, 8'h80, 8'hC0},
                 {CMD_ERASE,     3'b100, 8'h80, 8'hC0},
                 {CMD_UNPROT,    3'b100, 8'h80, 8'hC0},
                 {CMD_WORD_PROG, 3'b000, 8'h98, 8'hD8},
                 {CMD_PROTECT,   3'b000, 8'h98, 8'hC0},
                 {CMD_ERASE,     3'b000, 8'hA8, 8'hC0},
                 {CMD_UNPROT,    3'b000, 8'hA8, 8'hC0},
                 {CMD_WORD_PROG, 3'b110, 8'h92, 8'hD2},
                 {CMD_ERASE,     3'b110, 8'hA2, 8'hC0},
                 {CMD_WORD_PROG, 3'b101, 8'h90, 8'hD0},
                 {CMD_ERASE,     3'b101, 8'hA0, 8'hC0},
                 {CMD_BAD_SEQ,   3'b100, 8'hB0, 8'hF0}};
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        ahb(1'b1, OFS_CTRL, 32'h3);
        ahb(1'b0, 8'h0C, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        chkSt(8'h80, 1'b0);
        for (int p = 0; p < 2; p++) begin
            if (p == 1) begin
                op(CMD_ERASE, 1'b1, 1'b0, 1'b0);
                ahb(1'b1, OFS_CMD, {28'h0, CMD_SUSPEND});
                settle();
                chkSt(8'hC0, 1'b0);
            end
            op(CMD_WORD_PROG, 1'b1, 1'b0, 1'b0);
            ahb(1'b1, OFS_CMD, {28'h0, CMD_SUSPEND});
            settle();
            chkSt(p ? 8'hC4 : 8'h84, 1'b0);
            ahb(1'b1, OFS_CMD, {28'h0, CMD_RESUME});
            settle();
            chkSt(p ? 8'hC0 : 8'h80, 1'b0);
            foreach (rows[i]) begin
                op(rows[i][22:19], rows[i][18], rows[i][17], rows[i][16]);
                settle();
                chkSt(p ? rows[i][7:0] : rows[i][15:8], 1'b0);
                ahb(1'b1, OFS_CMD, {28'h0, CMD_CLEAR});
                settle();
                chkSt(p ? 8'hC0 : 8'h80, 1'b0);
            end
        end
        ahb(1'b1, OFS_CMD, {28'h0, CMD_RESUME});
        settle();
        chkSt(8'h80, 1'b0);
        op(CMD_WORD_PROG, 1'b0, 1'b0, 1'b0);
        settle();
        op(CMD_WORD_PROG, 1'b1, 1'b0, 1'b0);
        settle();
        chkSt(8'h98, 1'b1);
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        ahb(1'b1, OFS_CTRL, 32'h3);
        repeat (4) @(posedge mclk);
        chkSt(8'h80, 1'b0);
        giveVerdict();
    end
endmodule // tb
